// File: logic/gpc_map.svh
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH
// register offsets
`define GPC_OFF_DOUT0 8'h00
`define GPC_OFF_DOUT1 8'h04
`define GPC_OFF_STAT0 8'h10
`define GPC_OFF_STAT1 8'h11
`define GPC_OFF_EN0   8'h12
`define GPC_OFF_EN1   8'h13
`define GPC_OFF_CLR0  8'h14
`define GPC_OFF_CLR1  8'h15
`define GPC_OFF_SEL   8'hF0
`define GPC_OFF_CFG1  8'hF1
`define GPC_OFF_EVR   8'hF2
`define GPC_OFF_CFG2  8'hF3
// field positions
`define GPC_SEL_PORT_LO 4
`define GPC_SEL_PIN_LO  0
`define GPC_SEL_MASK    8'h77
`define GPC_B_PDN  7
`define GPC_B_DBNC 6
`define GPC_B_POL  5
`define GPC_B_LVL  4
`define GPC_B_LOCK 3
`define GPC_B_PUP  2
`define GPC_B_PP   1
`define GPC_B_DRV  0
`define GPC_B_SMI  1
`define GPC_B_IRQ  0
`define GPC_B_VDDL 4
`define GPC_NOEVT_PIN 13
// reset values, bit n = pin index port*8+pin
`define GPC_PUP_RST  16'h8E7E
`define GPC_PDN_RST  16'h1081
`define GPC_VDDL_RST 16'h0601
// debounce interval, a least time so it rounds up
`define GPC_DBNC_NS  16000
`define GPC_CLK_MHZ  250
`define GPC_DBNC_CYC ((`GPC_DBNC_NS * `GPC_CLK_MHZ + 999) / 1000)
`endif

// File: logic/gpc_pkg.sv
package gpc_pkg;
	// event detector state of one pin
	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        filt;
		logic        prev;
		logic [15:0] cnt;
		logic        evt;
	} gpc_det_t;

	// whole register and pin state of the block
	typedef struct packed {
		logic [7:0]       sel;
		logic [15:0][7:0] cfg;
		logic [15:0][1:0] evr;
		logic [15:0]      vddl;
		logic [15:0]      dout;
		logic [15:0]      stat;
		logic [15:0]      en;
		logic [7:0]       rd;
		logic             irq;
		logic             smi;
		logic [15:0]      pinDat;
		logic [15:0]      pinOeN;
	} gpc_state_t;
endpackage

// File: logic/gpc_evt_detect.sv
`timescale 1ns/10ps
module gpc_evt_detect
	import gpc_pkg::*;
#(
	parameter int DBNC_CYCLES = 4000
) (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic pinIn,
	input  wire logic dbncEn,
	input  wire logic polHigh,
	input  wire logic levelMode,
	output logic      evt
);
	gpc_det_t r;
	gpc_det_t next_r;
	logic     active;

	// the interval counter is only 16 bits wide
	if (DBNC_CYCLES < 1 || DBNC_CYCLES > 65535) begin : g_bad_dbnc
		$error("debounce count must fit the 16-bit counter");
	end

	// pin is synchronised, optionally filtered, then compared with polarity
	always_comb begin
		next_r = r;
		next_r.s1 = pinIn;
		next_r.s2 = r.s1;
		if (!dbncEn) begin
			next_r.filt = r.s2;
			next_r.cnt = 16'h0000;
		end else if (r.s2 == r.filt) begin
			next_r.cnt = 16'h0000; // a bounce back restarts the interval
		end else if (r.cnt == 16'(DBNC_CYCLES - 1)) begin
			next_r.filt = r.s2;
			next_r.cnt = 16'h0000;
		end else begin
			next_r.cnt = r.cnt + 16'h0001;
		end
		next_r.prev = r.filt;
		active = polHigh ? r.filt : !r.filt;
		if (levelMode) begin
			next_r.evt = active;
		end else begin
			next_r.evt = (r.filt != r.prev) && active;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign evt = r.evt;

	property p_dbnc_wait;
		@(posedge core_clk) disable iff (!rstn)
		$past(dbncEn) && $changed(r.filt) |-> $past(r.cnt) == 16'(DBNC_CYCLES - 1);
	endproperty
	a_dbnc_wait: assert property (p_dbnc_wait)
		else $error("debounced level moved before the interval ended");

	property p_level_evt;
		@(posedge core_clk) disable iff (!rstn)
		levelMode |=> r.evt == ($past(polHigh) ? $past(r.filt) : !$past(r.filt));
	endproperty
	a_level_evt: assert property (p_level_evt)
		else $error("level event does not follow polarity");
endmodule

// File: logic/gpc_pin_config.sv
`timescale 1ns/10ps
`include "gpc_map.svh"
module gpc_pin_config
	import gpc_pkg::*;
#(
	parameter int DBNC_CYCLES = `GPC_DBNC_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wrData,
	input  wire logic        wrStb,
	input  wire logic        rdStb,
	output logic      [7:0]  rdData,
	input  wire logic [15:0] pinIn,
	output logic      [15:0] pinDat,
	output logic      [15:0] pinOeN,
	output logic      [15:0] pullupEn,
	output logic      [15:0] pulldownEn,
	output logic      [15:0] vddLoad,
	output logic             irq,
	output logic             smi
);
	if (DBNC_CYCLES < 1 || DBNC_CYCLES > 65535) begin : g_bad_dbnc
		$error("debounce count must fit the 16-bit counter");
	end

	// pin index = port*8 + pin
	function automatic logic [3:0] selIdx(input logic [7:0] sel);
		return {sel[`GPC_SEL_PORT_LO], sel[`GPC_SEL_PIN_LO +: 3]};
	endfunction

	// only ports 0 and 1 exist, other port codes are reserved
	function automatic logic selOk(input logic [7:0] sel);
		return sel[`GPC_SEL_PORT_LO +: 3] <= 3'h1;
	endfunction

	// lock-aware merge of a configuration write
	function automatic logic [7:0] cfgMerge(
		input logic [7:0] old,
		input logic [7:0] wd,
		input logic       noEvt
	);
		logic [7:0] m;
		m = old;
		if (!old[`GPC_B_LOCK]) begin
			m[`GPC_B_PDN] = wd[`GPC_B_PDN];
			m[`GPC_B_PUP] = wd[`GPC_B_PUP];
			m[`GPC_B_PP] = wd[`GPC_B_PP];
			m[`GPC_B_DRV] = wd[`GPC_B_DRV];
			m[`GPC_B_LOCK] = wd[`GPC_B_LOCK];
		end
		if (!noEvt) begin
			m[`GPC_B_DBNC] = wd[`GPC_B_DBNC];
			m[`GPC_B_POL] = wd[`GPC_B_POL];
			m[`GPC_B_LVL] = wd[`GPC_B_LVL];
		end
		return m;
	endfunction

	// reset image: everything zero except pull table, vdd loads, idle drivers
	function automatic gpc_state_t rstState();
		gpc_state_t s;
		s = '0;
		for (int i = 0; i < 16; i++) begin
			s.cfg[i][`GPC_B_PUP] = 1'(`GPC_PUP_RST >> i);
			s.cfg[i][`GPC_B_PDN] = 1'(`GPC_PDN_RST >> i);
		end
		s.vddl = `GPC_VDDL_RST;
		s.pinOeN = 16'hFFFF;
		return s;
	endfunction

	localparam gpc_state_t RST_STATE = rstState();

	gpc_state_t  r;
	gpc_state_t  next_r;
	logic [15:0] evtVec;

	// one detector per event-capable pin
	for (genvar g = 0; g < 16; g++) begin : g_det
		if (g == `GPC_NOEVT_PIN) begin : g_none
			assign evtVec[g] = 1'b0;
		end else begin : g_evt
			gpc_evt_detect #(
				.DBNC_CYCLES (DBNC_CYCLES)
			) u_det (
				.core_clk  (core_clk),
				.rstn      (rstn),
				.pinIn     (pinIn[g]),
				.dbncEn    (r.cfg[g][`GPC_B_DBNC]),
				.polHigh   (r.cfg[g][`GPC_B_POL]),
				.levelMode (r.cfg[g][`GPC_B_LVL]),
				.evt       (evtVec[g])
			);
		end
	end

	// register writes and reads, sticky status, pin drivers
	always_comb begin
		logic [3:0]  idx;
		logic        ok;
		logic        locked;
		logic [3:0]  pi;
		logic [15:0] clr;
		logic        irqAny;
		logic        smiAny;
		next_r = r;
		idx = selIdx(r.sel);
		ok = selOk(r.sel);
		locked = r.cfg[idx][`GPC_B_LOCK];
		pi = 4'h0;
		clr = 16'h0000;
		irqAny = 1'b0;
		smiAny = 1'b0;
		next_r.rd = 8'h00;
		if (wrStb) begin
			case (addr)
				`GPC_OFF_SEL: begin
					next_r.sel = wrData & `GPC_SEL_MASK;
				end
				`GPC_OFF_CFG1: begin
					if (ok) begin
						next_r.cfg[idx] = cfgMerge(r.cfg[idx], wrData,
							idx == 4'(`GPC_NOEVT_PIN));
					end
				end
				`GPC_OFF_EVR: begin
					if (ok) begin
						next_r.evr[idx] = wrData[1:0];
					end
				end
				`GPC_OFF_CFG2: begin
					if (ok && !locked) begin
						next_r.vddl[idx] = wrData[`GPC_B_VDDL];
					end
				end
				`GPC_OFF_DOUT0, `GPC_OFF_DOUT1: begin
					for (int i = 0; i < 8; i++) begin
						pi = {addr == `GPC_OFF_DOUT1, 3'(i)};
						if (!r.cfg[pi][`GPC_B_LOCK]) begin
							next_r.dout[pi] = wrData[i];
						end
					end
				end
				`GPC_OFF_EN0: begin
					next_r.en[7:0] = wrData;
				end
				`GPC_OFF_EN1: begin
					next_r.en[15:8] = wrData;
				end
				`GPC_OFF_CLR0: begin
					clr[7:0] = wrData;
				end
				`GPC_OFF_CLR1: begin
					clr[15:8] = wrData;
				end
				default: begin
				end
			endcase
		end
		if (rdStb) begin
			case (addr)
				`GPC_OFF_SEL: begin
					next_r.rd = r.sel;
				end
				`GPC_OFF_CFG1: begin
					next_r.rd = ok ? r.cfg[idx] : 8'h00;
				end
				`GPC_OFF_EVR: begin
					next_r.rd = ok ? {6'h00, r.evr[idx]} : 8'h00;
				end
				`GPC_OFF_CFG2: begin
					next_r.rd = ok ? {3'h0, r.vddl[idx], 4'h0} : 8'h00;
				end
				`GPC_OFF_DOUT0: begin
					next_r.rd = r.dout[7:0];
				end
				`GPC_OFF_DOUT1: begin
					next_r.rd = r.dout[15:8];
				end
				`GPC_OFF_STAT0: begin
					next_r.rd = r.stat[7:0];
				end
				`GPC_OFF_STAT1: begin
					next_r.rd = r.stat[15:8];
				end
				`GPC_OFF_EN0: begin
					next_r.rd = r.en[7:0];
				end
				`GPC_OFF_EN1: begin
					next_r.rd = r.en[15:8];
				end
				default: begin
					next_r.rd = 8'h00; // clear registers are write-only
				end
			endcase
		end
		// a new event beats a clear landing in the same cycle
		next_r.stat = (r.stat & ~clr) | evtVec;
		for (int i = 0; i < 16; i++) begin
			irqAny = irqAny | (next_r.stat[i] & next_r.en[i]
				& next_r.evr[i][`GPC_B_IRQ]);
			smiAny = smiAny | (next_r.stat[i] & next_r.en[i]
				& next_r.evr[i][`GPC_B_SMI]);
			// open-drain only ever pulls low, so it drives when data is 0
			next_r.pinDat[i] = next_r.cfg[i][`GPC_B_PP] & next_r.dout[i];
			next_r.pinOeN[i] = !(next_r.cfg[i][`GPC_B_DRV]
				& (next_r.cfg[i][`GPC_B_PP] | !next_r.dout[i]));
		end
		next_r.irq = irqAny;
		next_r.smi = smiAny;
	end

	// lock survives everything but this reset
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			r <= RST_STATE;
		end else begin
			r <= next_r;
		end
	end

	// pull controls come straight from the stored configuration bits
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pullupEn[i] = r.cfg[i][`GPC_B_PUP];
			pulldownEn[i] = r.cfg[i][`GPC_B_PDN];
		end
	end

	assign rdData = r.rd;
	assign pinDat = r.pinDat;
	assign pinOeN = r.pinOeN;
	assign vddLoad = r.vddl;
	assign irq = r.irq;
	assign smi = r.smi;

	// helpers read only by the checks below
	logic [7:0]  selCfg;
	logic [3:0]  selPin;
	logic [15:0] routeIrq;
	logic [15:0] routeSmi;
	assign selCfg = r.cfg[selIdx(r.sel)];
	assign selPin = selIdx(r.sel);
	for (genvar g = 0; g < 16; g++) begin : g_route
		assign routeIrq[g] = r.evr[g][`GPC_B_IRQ];
		assign routeSmi[g] = r.evr[g][`GPC_B_SMI];
	end

	property p_sel_write;
		@(posedge core_clk) disable iff (!rstn)
		wrStb && addr == `GPC_OFF_SEL |=> r.sel == ($past(wrData) & `GPC_SEL_MASK);
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("selector write not stored");

	property p_cfg_read;
		@(posedge core_clk) disable iff (!rstn)
		rdStb && addr == `GPC_OFF_CFG1 && selOk(r.sel) |=> rdData == $past(selCfg);
	endproperty
	a_cfg_read: assert property (p_cfg_read)
		else $error("config read returned another pin");

	property p_pull_write;
		@(posedge core_clk) disable iff (!rstn)
		wrStb && addr == `GPC_OFF_CFG1 && selOk(r.sel) && !selCfg[`GPC_B_LOCK]
		|=> pullupEn[$past(selPin)] == $past(wrData[`GPC_B_PUP])
		&& pulldownEn[$past(selPin)] == $past(wrData[`GPC_B_PDN]);
	endproperty
	a_pull_write: assert property (p_pull_write)
		else $error("pull controls not updated by write");

	property p_pull_reset;
		@(posedge core_clk) disable iff (!rstn)
		$rose(rstn) |-> pullupEn == `GPC_PUP_RST && pulldownEn == `GPC_PDN_RST;
	endproperty
	a_pull_reset: assert property (p_pull_reset)
		else $error("pull reset values wrong");

	property p_noevt;
		@(posedge core_clk) disable iff (!rstn)
		1'b1 |-> r.cfg[`GPC_NOEVT_PIN][`GPC_B_DBNC:`GPC_B_LVL] == 3'h0;
	endproperty
	a_noevt: assert property (p_noevt)
		else $error("event bits of the eventless pin changed");

	property p_od;
		@(posedge core_clk) disable iff (!rstn)
		!pinOeN[0] && !r.cfg[0][`GPC_B_PP] |-> !pinDat[0] && !r.dout[0];
	endproperty
	a_od: assert property (p_od)
		else $error("open-drain pin driven high");

	property p_drv;
		@(posedge core_clk) disable iff (!rstn)
		!pinOeN[1] |-> r.cfg[1][`GPC_B_DRV];
	endproperty
	a_drv: assert property (p_drv)
		else $error("pin driven while driver disabled");

	property p_lock_write;
		@(posedge core_clk) disable iff (!rstn)
		wrStb && addr == `GPC_OFF_CFG1 && selOk(r.sel) && selCfg[`GPC_B_LOCK]
		|=> selCfg[3:0] == $past(selCfg[3:0])
		&& selCfg[`GPC_B_PDN] == $past(selCfg[`GPC_B_PDN]);
	endproperty
	a_lock_write: assert property (p_lock_write)
		else $error("locked config bits were written");

	property p_lock_hold;
		@(posedge core_clk) disable iff (!rstn)
		r.cfg[3][`GPC_B_LOCK] |=> r.cfg[3][`GPC_B_LOCK];
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("lock fell without reset");

	property p_evr_read;
		@(posedge core_clk) disable iff (!rstn)
		rdStb && addr == `GPC_OFF_EVR |=> rdData[7:2] == 6'h00;
	endproperty
	a_evr_read: assert property (p_evr_read)
		else $error("reserved routing bits read nonzero");

	property p_route;
		@(posedge core_clk) disable iff (!rstn)
		1'b1 |-> irq == ((r.stat & r.en & routeIrq) != 16'h0000)
		&& smi == ((r.stat & r.en & routeSmi) != 16'h0000);
	endproperty
	a_route: assert property (p_route)
		else $error("interrupt without a routed enabled event");

	property p_set_wins;
		@(posedge core_clk) disable iff (!rstn)
		$past(evtVec[0]) |-> r.stat[0];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost against clear");
endmodule

// File: bench/gpc_pin_model.sv
`timescale 1ns/10ps
module gpc_pin_model (
	input  wire logic        core_clk,
	input  wire logic [15:0] pinDat,
	input  wire logic [15:0] pinOeN,
	input  wire logic [15:0] pullupEn,
	input  wire logic [15:0] pulldownEn,
	input  wire logic [15:0] extDrv,
	input  wire logic [15:0] extLvl,
	output logic      [15:0] pinIn
);
	logic [15:0] flt = 16'h0000;

	// a pin nobody drives and nothing pulls wanders, so no stale level survives
	always @(posedge core_clk) begin
		flt <= ~flt;
	end

	// wire level: block driver first, then the attached device, then the pulls
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (!pinOeN[i])
				pinIn[i] = pinDat[i];
			else if (extDrv[i])
				pinIn[i] = extLvl[i];
			else if (pullupEn[i])
				pinIn[i] = 1'b1;
			else if (pulldownEn[i])
				pinIn[i] = 1'b0;
			else
				pinIn[i] = flt[i];
		end
	end
endmodule

// File: bench/gpc_pin_config_test.sv
`timescale 1ns/10ps
module gpc_pin_config_test;
	localparam logic [15:0] PUP = 16'h8E7E;
	localparam logic [15:0] PDN = 16'h1081;
	logic        core_clk   = 1'b0;
	logic        rstn       = 1'b0;
	logic        wrStb      = 1'b0;
	logic        rdStb      = 1'b0;
	logic        rdWas      = 1'b0;
	logic [7:0]  addr       = 8'h00;
	logic [7:0]  wrData     = 8'h00;
	logic [7:0]  d;
	logic [7:0]  rdData;
	logic [15:0] extDrv     = 16'h0000;
	logic [15:0] extLvl     = 16'h0000;
	logic [15:0] dv;
	logic [15:0] pinIn, pinDat, pinOeN, pullupEn, pulldownEn, vddLoad;
	logic        irq, smi;
	int          failures   = 0;
	int          checks     = 0;
	logic [7:0]  expQ[$];

	gpc_pin_config #(.DBNC_CYCLES(4)) DUT (.core_clk(core_clk), .rstn(rstn), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .pinIn(pinIn),
		.pinDat(pinDat), .pinOeN(pinOeN), .pullupEn(pullupEn), .pulldownEn(pulldownEn),
		.vddLoad(vddLoad), .irq(irq), .smi(smi));
	gpc_pin_model PINS (.core_clk(core_clk), .pinDat(pinDat), .pinOeN(pinOeN),
		.pullupEn(pullupEn), .pulldownEn(pulldownEn), .extDrv(extDrv), .extLvl(extLvl),
		.pinIn(pinIn));

	// 250 MHz core clock
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	task automatic wrap_up();
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		addr <= a;
		wrData <= v;
		wrStb <= 1'b1;
		@(posedge core_clk);
		wrStb <= 1'b0;
		#1;
	endtask

	// the expected value is queued when the read is issued
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		addr <= a;
		rdStb <= 1'b1;
		expQ.push_back(e);
		@(posedge core_clk);
		rdStb <= 1'b0;
	endtask

	task automatic sel(input int p);
		wr(8'hF0, {1'b0, 3'(p / 8), 1'b0, 3'(p % 8)});
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// read data is valid only in the cycle after the strobe, so look mid-cycle
	always @(posedge core_clk) rdWas <= rdStb;
	always @(negedge core_clk) begin
		if (rdWas)
			chk(16'(rdData), 16'(expQ.pop_front()));
	end

	// watchdog: the whole run needs a few hundred cycles
	initial begin
		#100000;
		failures++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'h3e6d));
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		chk(pullupEn, PUP);
		chk(pulldownEn, PDN);
		chk(vddLoad, 16'h0601);
		for (int i = 0; i < 16; i++) begin
			sel(i);
			rd(8'hF1, {PDN[i], 4'h0, PUP[i], 2'b00});
			rd(8'hF2, 8'h00);
		end
		wr(8'hF0, 8'hFF);
		rd(8'hF0, 8'h77);
		wr(8'hF0, 8'h20);
		rd(8'hF1, 8'h00);
		rd(8'h80, 8'h00);
		// random configs; both pulls never set together, lock kept for later
		dv = 16'($urandom);
		wr(8'h00, dv[7:0]);
		wr(8'h04, dv[15:8]);
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom);
			d[3] = 1'b0;
			if (d[2]) d[7] = 1'b0;
			sel(i);
			wr(8'hF1, d);
			chk(16'({pullupEn[i], pulldownEn[i]}), 16'({d[2], d[7]}));
			chk(16'(pinOeN[i]), 16'(!(d[0] && (d[1] || !dv[i]))));
			if (d[0] && d[1]) chk(16'(pinDat[i]), 16'(dv[i]));
			rd(8'hF1, i == 13 ? d & 8'h8F : d);
		end
		// events on pin 0 driven by the attached device
		wr(8'h12, 8'hFF);
		sel(0);
		wr(8'hF1, 8'h20);
		extDrv[0] = 1'b1;
		extLvl[0] = 1'b0;
		wt(12);
		wr(8'h14, 8'hFF);
		wr(8'hF2, 8'hFF);
		rd(8'hF2, 8'h03);
		wr(8'hF2, 8'h01);
		chk(16'({irq, smi}), 16'h0);
		extLvl[0] = 1'b1;
		wt(12);
		chk(16'({irq, smi}), 16'h2);
		wr(8'h14, 8'h01);
		wt(2);
		chk(16'({irq, smi}), 16'h0);
		wr(8'hF2, 8'h02);
		extLvl[0] = 1'b0;
		wt(12);
		chk(16'({irq, smi}), 16'h0);
		extLvl[0] = 1'b1;
		wt(12);
		chk(16'({irq, smi}), 16'h1);
		wr(8'hF1, 8'h30);
		wr(8'h14, 8'h01);
		wt(12);
		chk(16'({irq, smi}), 16'h1);
		wr(8'hF1, 8'h10);
		wt(12);
		wr(8'h14, 8'h01);
		wt(12);
		chk(16'({irq, smi}), 16'h0);
		// a pulse shorter than the debounce interval must be swallowed
		wr(8'hF1, 8'h60);
		extLvl[0] = 1'b0;
		wt(12);
		wr(8'h14, 8'h01);
		extLvl[0] = 1'b1;
		wt(2);
		extLvl[0] = 1'b0;
		wt(12);
		chk(16'({irq, smi}), 16'h0);
		extLvl[0] = 1'b1;
		wt(16);
		chk(16'({irq, smi}), 16'h1);
		wr(8'hF2, 8'h00);
		wt(2);
		chk(16'({irq, smi}), 16'h0);
		wr(8'hF0, 8'h30);
		rd(8'hF2, 8'h00);
		// lock pin 3 while driving push-pull
		sel(3);
		wr(8'h00, 8'hFF);
		wr(8'hF1, 8'h0B);
		wr(8'hF1, 8'hF4);
		rd(8'hF1, 8'h7B);
		wr(8'hF1, 8'h00);
		rd(8'hF1, 8'h0B);
		chk(16'(pinOeN[3]), 16'h0);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h08);
		wr(8'hF3, 8'h10);
		rd(8'hF3, 8'h00);
		// second reset must release the lock
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		chk(pullupEn, PUP);
		sel(3);
		rd(8'hF1, 8'h04);
		wr(8'hF1, 8'h01);
		rd(8'hF1, 8'h01);
		wr(8'hF3, 8'h10);
		chk(vddLoad, 16'h0609);
		rd(8'hF3, 8'h10);
		wt(3);
		wrap_up();
	end
endmodule
